//--- verilog/rtc_bus_port.sv
// Real-time clock with 64-byte map behind a multiplexed address/data bus.
// Assumes bus pins and power sense are asynchronous.
`include "rtc_params.svh"

// Contract
// RULE1: Host keeps select low and steady through a cycle.
// RULE2: Deselected cycles have no effect.
// RULE3: Bus outputs float while deselected.
// RULE4: Deselect isolates address, data, strobe, read/write inputs.
// RULE5: Separate-strobe mode: read/write pin is a low write pulse.
// RULE6: Interrupt low while a flag and its enable are set.
// RULE7: Interrupt floats otherwise.
// RULE8: Reset keeps time, calendar and RAM.
// RULE9: Reset clears enables, flags, square-wave enable; interrupt floats.
// RULE10: Power sense low clears valid bit.
// RULE11: Valid-status read with power sense high sets valid bit.
// RULE12: Map: 10 time, 4 control, 50 RAM bytes.
// RULE13: Status, valid, divider bit 7, seconds bit 7 read-only; latter reads zero.
// RULE14: Freeze bit stops time updates.
// RULE15: Time bytes binary or BCD per format bit.
// RULE16: Software rewrites time bytes after format changes.
// RULE17: Hour-format bit selects 1-12 or 0-23.
// RULE18: 12-hour format: hour bit 7 marks PM.
// RULE19: Time advances each second; time reads undefined meanwhile.
// RULE20: Lockout 248 us fast time bases, 1948 us slow.
// RULE21: Time bytes at offsets 0 to 9; seconds, minutes 0-59.
// RULE22: Weekday 1-7 Sunday 1, day 1-31, month 1-12.
// RULE23: Address strobe fall samples data strobe for bus style.
// RULE24: Address strobe fall latches six low bus lines.
// RULE25: Strobe mode: read/write high reads, low writes.
// RULE26: Status read clears set flags; new events held until read ends.
// RULE27: Update carries seconds to month, respecting month lengths.
// RULE28: RAM and control stay accessible during update.
module rtc_bus_port #(
   parameter int SECOND_CYC    = `SECOND_US * `CLK_MHZ,
   parameter int LOCK_SLOW_CYC = `LOCK_SLOW_US * `CLK_MHZ,
   parameter int PERIOD_CYC    = `PERIOD_BASE_US * `CLK_MHZ
) (
   input  wire logic             clock,
   input  wire logic             nrst,
   input  wire rtc_pkg::busPins_t busPins,
   input  wire logic [7:0]       muxedAddrDataIn,
   output logic      [7:0]       muxedAddrDataOut,
   output logic                  muxedAddrDataOe,
   output logic                  irqOut,
   output logic                  irqOe,
   input  wire logic             powerSenseIn,
   output logic                  squareWaveOut
);
   import rtc_pkg::*;

   localparam int LOCK_FAST_CYC = `LOCK_FAST_US * `CLK_MHZ;
   localparam int CW = 32;

   // ****************************************************************
   // Functions
   // ****************************************************************
   function automatic logic [7:0] toBin(input logic [7:0] v, input logic bin);
      toBin = bin ? v : 8'(v[7:4]) * 8'h0A + 8'(v[3:0]);
   endfunction

   function automatic logic [7:0] fromBin(input logic [7:0] v, input logic bin);
      logic [7:0] t;
      t = 8'(v / 8'h0A);
      fromBin = bin ? v : {t[3:0], 4'(v % 8'h0A)};
   endfunction

   function automatic logic [7:0] monthLen(input logic [7:0] m, input logic [7:0] y);
      unique case (m)
         8'h04, 8'h06, 8'h09, 8'h0B: monthLen = 8'h1E;
         8'h02:                      monthLen = (y[1:0] == 2'h0) ? 8'h1D : 8'h1C;
         default:                    monthLen = 8'h1F;
      endcase
   endfunction

   // Alarm byte matches when equal or marked don't care
   function automatic logic almHit(input logic [7:0] a, input logic [7:0] t);
      almHit = (a[7:6] == `DONT_CARE) || (a == t);
   endfunction

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   // Three stages; a level counts once stages two and three agree
   logic [12:0] s1_r, s2_r, s3_r, pin_r, pin_nxt;
   logic        psIn;
   always_comb begin
      pin_nxt = pin_r;
      for (int i = 0; i < 13; i++) begin
         if (s2_r[i] == s3_r[i]) begin
            pin_nxt[i] = s3_r[i];
         end
      end
   end
   always_ff @(posedge clock) begin
      if (!nrst) begin
         s1_r  <= 13'h1F00;
         s2_r  <= 13'h1F00;
         s3_r  <= 13'h1F00;
         pin_r <= 13'h1F00;
      end else begin
         s1_r  <= {powerSenseIn, busPins, muxedAddrDataIn};
         s2_r  <= s1_r;
         s3_r  <= s2_r;
         pin_r <= pin_nxt;
      end
   end
   busPins_t   bp;
   logic [7:0] adIn;
   assign psIn = pin_r[12];
   assign bp   = busPins_t'(pin_r[11:8]);
   assign adIn = pin_r[7:0];

   // ****************************************************************
   // Bus decode
   // ****************************************************************
   // RULE4: inputs gated by select
   logic csOn, alsG, dsG, rwG;
   assign csOn = !bp.chipSelectN;
   assign alsG = csOn & bp.addressLatchStrobe;
   assign dsG  = csOn & bp.busStrobe;
   assign rwG  = csOn ? bp.readWriteN : 1'b1;

   logic       alsPrev_r, strobeStyle_r, rdPrev_r, wrPrev_r;
   logic [5:0] addr_r;
   logic       alsPrev_nxt, strobeStyle_nxt;
   logic [5:0] addr_nxt;
   logic       rdEn, wrEn, rdStart, rdEnd, wrEnd;

   // RULE25: read/write level qualified by strobe
   // RULE5: separate style uses write pulse
   always_comb begin
      rdEn = !alsG && (strobeStyle_nxt ? (csOn & !bp.busStrobe) : (dsG & rwG));
      wrEn = !alsG && (strobeStyle_nxt ? (csOn & !bp.readWriteN) : (dsG & !rwG));
   end
   assign rdStart = rdEn & !rdPrev_r;
   assign rdEnd   = !rdEn & rdPrev_r;
   // RULE2: write committed on trailing edge only while selected
   assign wrEnd   = !wrEn & wrPrev_r & csOn;

   // RULE23: style sampled at address strobe fall
   // RULE24: address from six low lines
   always_comb begin
      alsPrev_nxt     = alsG;
      strobeStyle_nxt = strobeStyle_r;
      addr_nxt        = addr_r;
      if (alsPrev_r && !alsG && csOn) begin
         strobeStyle_nxt = bp.busStrobe;
         addr_nxt        = adIn[5:0];
      end
   end
   always_ff @(posedge clock) begin
      if (!nrst) begin
         alsPrev_r     <= 1'b0;
         strobeStyle_r <= 1'b0;
         addr_r        <= 6'h00;
         rdPrev_r      <= 1'b0;
         wrPrev_r      <= 1'b0;
      end else begin
         alsPrev_r     <= alsPrev_nxt;
         strobeStyle_r <= strobeStyle_nxt;
         addr_r        <= addr_nxt;
         rdPrev_r      <= rdEn;
         wrPrev_r      <= wrEn;
      end
   end

   // ****************************************************************
   // Byte map storage
   // ****************************************************************
   // RULE12: one array for time bytes and user RAM
   // RULE8: no reset on stored bytes
   logic [7:0] mem[`MAP_BYTES];
   logic [7:0] wrData_r, wrData_nxt;
   // Power-up: divider held, no periodic rate
   logic [2:0] divSel_r = 3'h7, divSel_nxt;
   logic [3:0] rate_r = 4'h0, rate_nxt;
   logic       setBit_r, dmBit_r, h24Bit_r, dseBit_r;
   logic       setBit_nxt, dmBit_nxt, h24Bit_nxt, dseBit_nxt;
   irqBits_t   irqEn_r, irqEn_nxt;
   logic       sqwEn_r, sqwEn_nxt;
   logic       isTime;
   updState_t  upd_r = UPD_IDLE, upd_nxt;
   logic       updDone;
   logic [7:0] nsec, nmin, nhr, nwd, nmd, nmon, nyr;

   // RULE21: fixed time offsets
   assign isTime     = (addr_r <= `OFF_YEAR);
   assign wrData_nxt = wrEn ? adIn : wrData_r;

   // Control fields written by the host
   always_comb begin
      divSel_nxt = divSel_r;
      rate_nxt   = rate_r;
      setBit_nxt = setBit_r;
      dmBit_nxt  = dmBit_r;
      h24Bit_nxt = h24Bit_r;
      dseBit_nxt = dseBit_r;
      irqEn_nxt  = irqEn_r;
      sqwEn_nxt  = sqwEn_r;
      // RULE13: divider bit 7 not writable
      if (wrEnd && addr_r == `OFF_REG_A) begin
         divSel_nxt = wrData_r[6:4];
         rate_nxt   = wrData_r[3:0];
      end
      if (wrEnd && addr_r == `OFF_REG_B) begin
         setBit_nxt = wrData_r[`B_SET];
         irqEn_nxt  = irqBits_t'(wrData_r[`B_PIE:`B_UIE]);
         sqwEn_nxt  = wrData_r[`B_SQUARE_WAVE_EN];
         dmBit_nxt  = wrData_r[`B_DM];
         h24Bit_nxt = wrData_r[`B_H24];
         dseBit_nxt = wrData_r[0];
      end
   end
   // Kept through reset
   always_ff @(posedge clock) begin
      wrData_r <= wrData_nxt;
      divSel_r <= divSel_nxt;
      rate_r   <= rate_nxt;
      setBit_r <= setBit_nxt;
      dmBit_r  <= dmBit_nxt;
      h24Bit_r <= h24Bit_nxt;
      dseBit_r <= dseBit_nxt;
   end
   // RULE9: reset clears enables
   always_ff @(posedge clock) begin
      if (!nrst) begin
         irqEn_r <= `EN_RESET;
         sqwEn_r <= 1'b0;
      end else begin
         irqEn_r <= irqEn_nxt;
         sqwEn_r <= sqwEn_nxt;
      end
   end

   // Host writes; time bytes locked during update
   // RULE28: RAM and control remain writable during update
   always_ff @(posedge clock) begin
      if (updDone) begin
         mem[`OFF_SEC]     <= nsec;
         mem[`OFF_MIN]     <= nmin;
         mem[`OFF_HOUR]    <= nhr;
         mem[`OFF_WEEKDAY] <= nwd;
         mem[`OFF_MDAY]    <= nmd;
         mem[`OFF_MONTH]   <= nmon;
         mem[`OFF_YEAR]    <= nyr;
      end
      // RULE13: seconds bit 7 stored as zero
      if (wrEnd && addr_r == `OFF_SEC && upd_r == UPD_IDLE) begin
         mem[addr_r] <= {1'b0, wrData_r[6:0]};
      end else if (wrEnd && addr_r > `OFF_REG_D) begin
         mem[addr_r] <= wrData_r;
      end else if (wrEnd && isTime && addr_r != `OFF_SEC && upd_r == UPD_IDLE) begin
         mem[addr_r] <= wrData_r;
      end
   end

   // ****************************************************************
   // Time advance
   // ****************************************************************
   // RULE15: work in binary, store in selected format
   // RULE27: carry chain with month lengths
   // RULE17: hour range per format
   // RULE18: PM flag in bit 7
   // RULE22: weekday, day, month ranges
   logic [7:0] bs, bm, bh, bw, bd, bmo, by, hb;
   logic       pm, cMin, cHr, cDay, cMon;
   always_comb begin
      bs   = toBin(mem[`OFF_SEC], dmBit_r);
      bm   = toBin(mem[`OFF_MIN], dmBit_r);
      bh   = toBin({1'b0, mem[`OFF_HOUR][6:0]}, dmBit_r);
      pm   = mem[`OFF_HOUR][7] & !h24Bit_r;
      bw   = toBin(mem[`OFF_WEEKDAY], dmBit_r);
      bd   = toBin(mem[`OFF_MDAY], dmBit_r);
      bmo  = toBin(mem[`OFF_MONTH], dmBit_r);
      by   = toBin(mem[`OFF_YEAR], dmBit_r);
      cMin = (bs >= 8'h3B);
      bs   = cMin ? 8'h00 : 8'(bs + 8'h01);
      cHr  = cMin && (bm >= 8'h3B);
      bm   = cMin ? (cHr ? 8'h00 : 8'(bm + 8'h01)) : bm;
      cDay = 1'b0;
      if (cHr) begin
         if (h24Bit_r) begin
            cDay = (bh >= 8'h17);
            bh   = cDay ? 8'h00 : 8'(bh + 8'h01);
         end else begin
            cDay = pm && (bh == 8'h0B);
            if (bh == 8'h0B) begin
               pm = !pm;
            end
            bh = (bh >= 8'h0C) ? 8'h01 : 8'(bh + 8'h01);
         end
      end
      cMon = cDay && (bd >= monthLen(bmo, by));
      if (cDay) begin
         bw = (bw >= 8'h07) ? 8'h01 : 8'(bw + 8'h01);
         bd = cMon ? 8'h01 : 8'(bd + 8'h01);
      end
      if (cMon && bmo >= 8'h0C) begin
         bmo = 8'h01;
         by  = (by >= 8'h63) ? 8'h00 : 8'(by + 8'h01);
      end else if (cMon) begin
         bmo = 8'(bmo + 8'h01);
      end
      nsec = fromBin(bs, dmBit_r);
      nmin = fromBin(bm, dmBit_r);
      hb   = fromBin(bh, dmBit_r);
      nhr  = {pm, hb[6:0]};
      nwd  = fromBin(bw, dmBit_r);
      nmd  = fromBin(bd, dmBit_r);
      nmon = fromBin(bmo, dmBit_r);
      nyr  = fromBin(by, dmBit_r);
   end

   // ****************************************************************
   // Second tick and update lockout
   // ****************************************************************
   // Held divider restarts the second count
   logic [CW-1:0] secCnt_r, secCnt_nxt, lockCnt_r, lockCnt_nxt;
   logic          secTick, divHold;
   assign divHold = (divSel_r[2:1] == `DIV_HOLD) || (divSel_r > `DIV_SLOW);
   assign secTick = !divHold && (secCnt_r == CW'(SECOND_CYC - 1));
   assign updDone = (upd_r == UPD_LOCK) && (lockCnt_r == '0);

   // RULE14: freeze bit skips the update
   // RULE19: one update per second
   // RULE20: lockout length per time base
   always_comb begin
      secCnt_nxt  = (divHold || secTick) ? '0 : CW'(secCnt_r + 1'b1);
      upd_nxt     = upd_r;
      lockCnt_nxt = lockCnt_r;
      unique case (upd_r)
         UPD_IDLE: begin
            if (secTick && !setBit_r) begin
               upd_nxt     = UPD_LOCK;
               lockCnt_nxt = (divSel_r == `DIV_SLOW) ? CW'(LOCK_SLOW_CYC - 1) : CW'(LOCK_FAST_CYC - 1);
            end
         end
         UPD_LOCK: begin
            if (lockCnt_r == '0) begin
               upd_nxt = UPD_IDLE;
            end else begin
               lockCnt_nxt = CW'(lockCnt_r - 1'b1);
            end
         end
      endcase
   end
   // Divider and time keep running through reset
   always_ff @(posedge clock) begin
      secCnt_r  <= secCnt_nxt;
      upd_r     <= upd_nxt;
      lockCnt_r <= lockCnt_nxt;
   end

   // ****************************************************************
   // Periodic tick and square wave
   // ****************************************************************
   // Simplified rate: period doubles per rate step
   logic [CW-1:0] perCnt_r, perCnt_nxt;
   logic          perTick, sqw_r, sqw_nxt;
   assign perTick    = (rate_r != 4'h0) && !divHold && (perCnt_r >= CW'(PERIOD_CYC << (rate_r - 4'h1)) - 1);
   assign perCnt_nxt = (perTick || rate_r == 4'h0 || divHold) ? '0 : CW'(perCnt_r + 1'b1);
   assign sqw_nxt    = sqwEn_r ? (sqw_r ^ perTick) : 1'b0;
   always_ff @(posedge clock) begin
      perCnt_r <= perCnt_nxt;
      if (!nrst) begin
         sqw_r <= 1'b0;
      end else begin
         sqw_r <= sqw_nxt;
      end
   end
   assign squareWaveOut = sqw_r;

   // ****************************************************************
   // Interrupt flags
   // ****************************************************************
   irqBits_t flags_r, flags_nxt, held_r, held_nxt, snap_r, snap_nxt, events;
   logic     readingC_r, readingC_nxt, irqAct;
   always_comb begin
      events.update   = updDone;
      events.alarm    = updDone && almHit(mem[`OFF_SEC_ALM], nsec) && almHit(mem[`OFF_MIN_ALM], nmin)
                        && almHit(mem[`OFF_HOUR_ALM], nhr);
      events.periodic = perTick;
   end
   // RULE26: flags read are cleared; events during the read wait
   always_comb begin
      flags_nxt    = flags_r;
      held_nxt     = held_r;
      snap_nxt     = snap_r;
      readingC_nxt = readingC_r;
      if (rdStart && addr_r == `OFF_REG_C) begin
         readingC_nxt = 1'b1;
         snap_nxt     = flags_r;
      end
      if (readingC_nxt) begin
         held_nxt = held_r | events;
      end else begin
         flags_nxt = flags_r | events;
      end
      if (rdEnd && readingC_r) begin
         readingC_nxt = 1'b0;
         flags_nxt    = (flags_r & ~snap_r) | held_r | events;
         held_nxt     = `FLAGS_RESET;
      end
   end
   // RULE9: reset clears flags
   always_ff @(posedge clock) begin
      if (!nrst) begin
         flags_r    <= `FLAGS_RESET;
         held_r     <= `FLAGS_RESET;
         snap_r     <= `FLAGS_RESET;
         readingC_r <= 1'b0;
      end else begin
         flags_r    <= flags_nxt;
         held_r     <= held_nxt;
         snap_r     <= snap_nxt;
         readingC_r <= readingC_nxt;
      end
   end
   // RULE6: drive low while flag and enable meet
   // RULE7: released otherwise, open drain
   assign irqAct = |(flags_r & irqEn_r);
   assign irqOut = 1'b0;
   assign irqOe  = irqAct;

   // ****************************************************************
   // Valid RAM and time bit
   // ****************************************************************
   logic vrt_r, vrt_nxt;
   // RULE10: power sense low clears
   // RULE11: status read with power present sets
   always_comb begin
      vrt_nxt = vrt_r;
      if (!psIn) begin
         vrt_nxt = 1'b0;
      end else if (rdStart && addr_r == `OFF_REG_D) begin
         vrt_nxt = 1'b1;
      end
   end
   // Unaffected by reset; only power sense and status reads govern it
   always_ff @(posedge clock) begin
      vrt_r <= vrt_nxt;
   end

   // ****************************************************************
   // Read path
   // ****************************************************************
   logic [7:0] rdByte, dout_r, dout_nxt;
   // RULE19: time bytes undefined during lockout
   // RULE13: read-only fields shown
   always_comb begin
      unique case (addr_r)
         `OFF_REG_A: rdByte = {upd_r == UPD_LOCK, divSel_r, rate_r};
         `OFF_REG_B: rdByte = {setBit_r, irqEn_r, sqwEn_r, dmBit_r, h24Bit_r, dseBit_r};
         `OFF_REG_C: rdByte = {irqAct, flags_r, 4'h0};
         `OFF_REG_D: rdByte = {vrt_r, 7'h00};
         default:    rdByte = (isTime && upd_r == UPD_LOCK) ? `UNDEF_BYTE : mem[addr_r];
      endcase
      dout_nxt = rdStart ? rdByte : dout_r;
   end
   always_ff @(posedge clock) begin
      if (!nrst) begin
         dout_r <= 8'h00;
      end else begin
         dout_r <= dout_nxt;
      end
   end
   // RULE3: drive only during a selected read
   assign muxedAddrDataOut = dout_r;
   assign muxedAddrDataOe  = rdEn & rdPrev_r;
endmodule

//--- verilog/rtc_params.svh
// Offsets, field positions, reset values and timing of the clock block.
// Assumes a 10 MHz system clock; included by bare name from the design file.
`ifndef RTC_PARAMS_SVH
`define RTC_PARAMS_SVH

// ****************************************************************
// Byte map
// ****************************************************************
`define OFF_SEC        6'h00
`define OFF_SEC_ALM    6'h01
`define OFF_MIN        6'h02
`define OFF_MIN_ALM    6'h03
`define OFF_HOUR       6'h04
`define OFF_HOUR_ALM   6'h05
`define OFF_WEEKDAY    6'h06
`define OFF_MDAY       6'h07
`define OFF_MONTH      6'h08
`define OFF_YEAR       6'h09
`define OFF_REG_A      6'h0A
`define OFF_REG_B      6'h0B
`define OFF_REG_C      6'h0C
`define OFF_REG_D      6'h0D
`define MAP_BYTES      64

// ****************************************************************
// Field positions
// ****************************************************************
`define B_SET          7
`define B_PIE          6
`define B_AIE          5
`define B_UIE          4
`define B_SQUARE_WAVE_EN         3
`define B_DM           2
`define B_H24          1

// ****************************************************************
// Reset values and codes
// ****************************************************************
`define FLAGS_RESET    3'h0
`define EN_RESET       3'h0
`define DIV_HOLD       2'h3
`define DIV_SLOW       3'h2
`define UNDEF_BYTE     8'hFF
`define DONT_CARE      2'h3

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_MHZ        10
`define SECOND_US      1000000
`define LOCK_FAST_US   248
`define LOCK_SLOW_US   1948
`define PERIOD_BASE_US 30

`endif

//--- verilog/rtc_pkg.sv
// Types shared by the clock and RAM block.
// Assumes rtc_params.svh supplies the numeric constants.
package rtc_pkg;
   // Bus control pins as they arrive from the processor
   typedef struct packed {
      logic chipSelectN;
      logic addressLatchStrobe;
      logic busStrobe;
      logic readWriteN;
   } busPins_t;

   // Interrupt flags, enables share this order
   typedef struct packed {
      logic periodic;
      logic alarm;
      logic update;
   } irqBits_t;

   typedef enum logic { UPD_IDLE, UPD_LOCK } updState_t;
endpackage

//--- test/rtc_bus_port_props.sv
// Checker on the bus and interrupt pins of rtc_bus_port.
// Assumes select held low over each whole cycle.
module rtc_bus_port_props #(
   parameter int SECOND_CYC    = 200,
   parameter int LOCK_SLOW_CYC = 40,
   parameter int PERIOD_CYC    = 4
) (
   input wire logic              clock,
   input wire logic              nrst,
   input wire rtc_pkg::busPins_t busPins,
   input wire logic [7:0]        muxedAddrDataIn,
   input wire logic [7:0]        muxedAddrDataOut,
   input wire logic              muxedAddrDataOe,
   input wire logic              irqOut,
   input wire logic              irqOe,
   input wire logic              powerSenseIn,
   input wire logic              squareWaveOut
);
   // ****************************************************************
   // Bus and interrupt properties
   // ****************************************************************
   default clocking @(posedge clock); endclocking
   // Deselect seen after synchroniser lag
   a_cs_high_float: assert property (disable iff (!nrst) busPins.chipSelectN [*5] |-> !muxedAddrDataOe)
      else $error("bus driven while deselected");
   a_cs_gates_read: assert property (disable iff (!nrst) $rose(muxedAddrDataOe) |->
      !$past(busPins.chipSelectN, 2) && !$past(busPins.chipSelectN, 6)) else $error("read while deselected");
   a_read_not_write: assert property (disable iff (!nrst) $rose(muxedAddrDataOe) |-> $past(busPins.readWriteN, 2))
      else $error("bus driven during a write");
   a_data_stands: assert property (disable iff (!nrst) muxedAddrDataOe && $past(muxedAddrDataOe) |->
      $stable(muxedAddrDataOut)) else $error("read data moved");
   a_strobe_end_drop: assert property (disable iff (!nrst) $fell(busPins.busStrobe) && muxedAddrDataOe |->
      ##[1:6] !muxedAddrDataOe) else $error("bus held after strobe end");
   a_rd_strobe_drop: assert property (disable iff (!nrst) $rose(busPins.busStrobe) && muxedAddrDataOe |->
      ##[1:6] !muxedAddrDataOe) else $error("bus held after read strobe");
   a_irq_reset_float: assert property (!nrst |=> !irqOe)
      else $error("interrupt driven in reset");
   a_sq_reset_low: assert property (!nrst |=> !squareWaveOut && !muxedAddrDataOe)
      else $error("outputs active in reset");
   a_irq_open_drain: assert property (disable iff (!nrst) irqOut == 1'b0)
      else $error("interrupt pin drives high");
   // Release needs a reset or a selected bus cycle
   a_irq_held: assert property (disable iff (!nrst) $fell(irqOe) |-> !$past(nrst) ||
      !$past(busPins.chipSelectN, 2) || !$past(busPins.chipSelectN, 5)) else $error("interrupt dropped alone");
   c_read: cover property ($rose(muxedAddrDataOe));
   c_irq_up: cover property ($rose(irqOe));
   c_irq_down: cover property (nrst && $fell(irqOe));
endmodule

bind rtc_bus_port rtc_bus_port_props #(.SECOND_CYC(SECOND_CYC), .LOCK_SLOW_CYC(LOCK_SLOW_CYC),
   .PERIOD_CYC(PERIOD_CYC)) u_props (.clock(clock), .nrst(nrst), .busPins(busPins),
   .muxedAddrDataIn(muxedAddrDataIn), .muxedAddrDataOut(muxedAddrDataOut), .muxedAddrDataOe(muxedAddrDataOe),
   .irqOut(irqOut), .irqOe(irqOe), .powerSenseIn(powerSenseIn), .squareWaveOut(squareWaveOut));

//--- test/rtc_host.sv
// Host processor model for the multiplexed bus of the clock block.
// Assumes pins pass slow synchronisers.
module rtc_host (
   input  wire logic         clock,
   output rtc_pkg::busPins_t busPins,
   output logic [7:0]        addrData,
   input  wire logic [7:0]   readData,
   input  wire logic         readOe,
   output logic [7:0]        rdData,
   output logic              rdDone
);
   import rtc_pkg::*;
   // Idle bus: deselected, strobes inactive
   initial begin
      busPins = '{1'b1, 1'b0, 1'b0, 1'b1};
      addrData = 8'h00;
      rdData = 8'h00;
      rdDone = 1'b0;
   end
   task automatic hold(input int n);
      repeat (n) @(posedge clock);
   endtask
   // chip select steady
   // One byte cycle, each level held past synchroniser lag
   task automatic cyc(input logic sep, input logic csN, input logic wr, input logic [5:0] a, input logic [7:0] d);
      busPins <= '{csN, 1'b1, sep, 1'b1};
      addrData <= {2'h0, a};
      hold(6);
      busPins.addressLatchStrobe <= 1'b0;
      hold(6);
      // Released lines show the inverse
      addrData <= wr ? d : ~{2'h0, a};
      busPins.busStrobe <= wr | ~sep;
      busPins.readWriteN <= ~wr;
      hold(8);
      rdData <= readOe ? readData : 8'hXX;
      rdDone <= ~wr & ~csN;
      busPins.busStrobe <= sep;
      busPins.readWriteN <= 1'b1;
      hold(1);
      rdDone <= 1'b0;
      hold(5);
   endtask
endmodule

//--- test/testbench.sv
// Self-checking bench for rtc_bus_port with a host model on its bus.
// Assumes shortened second and slow-base lockout counts.
`include "rtc_params.svh"
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import rtc_pkg::*;
   localparam int SEC = 2000;
   logic clock, nrst, powerSenseIn, rdDone, oe, irqOut, irqOe, sqOut;
   logic [7:0] adHost, adBus, adOut, rdData, ramD;
   logic [5:0] ramA;
   logic [15:0] note;
   logic [15:0] expQ[$];
   busPins_t busPins;
   int bad_count, samples_checked;
   logic [7:0] tv[10] = '{8'hD9, 8'h00, 8'h59, 8'h00, 8'h91, 8'h12, 8'h07, 8'h31, 8'h12, 8'h09};
   logic [7:0] tn[10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h12, 8'h12, 8'h01, 8'h01, 8'h01, 8'h10};
   // Compare with case equality so unknowns never match
   `define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
      bad_count++; $display("BAD %0t got %h want %h", $time, g, e); end end
   // Block wins the bus while it drives
   assign adBus = oe ? adOut : adHost;
   rtc_bus_port #(.SECOND_CYC(SEC), .LOCK_SLOW_CYC(40), .PERIOD_CYC(4)) u_rtc_bus_port (.clock(clock), .nrst(nrst),
      .busPins(busPins), .muxedAddrDataIn(adBus), .muxedAddrDataOut(adOut), .muxedAddrDataOe(oe), .irqOut(irqOut),
      .irqOe(irqOe), .powerSenseIn(powerSenseIn), .squareWaveOut(sqOut));
   rtc_host u_rtc_host (.clock(clock), .busPins(busPins), .addrData(adHost), .readData(adOut), .readOe(oe),
      .rdData(rdData), .rdDone(rdDone));
   task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic sep = 0, input logic csN = 0);
      u_rtc_host.cyc(sep, csN, 1'b1, a, d);
   endtask
   // Notes the expected byte and its mask
   task automatic rd(input logic [5:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF, input logic sep = 0);
      expQ.push_back({m, e});
      u_rtc_host.cyc(sep, 1'b0, 1'b0, a, 8'h00);
   endtask
   task automatic stop_test;
      $display("checks %0d bad %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // Judge each read by the oldest note
   always @(posedge clock) begin
      if (rdDone === 1'b1) begin
         note = expQ.pop_front();
         `CHK(rdData & note[15:8], note[7:0])
      end
   end
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   // Watchdog far past the expected run
   initial begin
      repeat (40000) @(posedge clock);
      bad_count++;
      stop_test();
   end
   initial begin
      nrst = 1'b0;
      powerSenseIn = 1'b1;
      void'($urandom(32'h2DCC73E2));
      repeat (3) @(posedge clock);
      nrst <= 1'b1;
      @(posedge clock);
      // RAM, both styles; deselected write must not land
      for (int i = 0; i < 4; i++) begin
         ramA = 6'h0E + 6'($urandom_range(49));
         ramD = 8'($urandom);
         wr(ramA, ramD, i[0]);
         wr(ramA, ~ramD, 1'b0, 1'b1);
         rd(ramA, ramD, 8'hFF, ~i[0]);
      end
      $display("test ram done");
      // Frozen BCD 12-hour time one second before year end
      wr(`OFF_REG_B, 8'h80);
      wr(`OFF_REG_A, 8'h60);
      wr(`OFF_REG_A, 8'h20);
      foreach (tv[i]) wr(6'(i), tv[i]);
      wr(`OFF_REG_C, 8'hFF);
      repeat (2 * SEC) @(posedge clock);
      rd(`OFF_SEC, 8'h59);
      rd(`OFF_REG_C, 8'h00);
      $display("test freeze done");
      wr(`OFF_REG_B, 8'h10);
      for (int n = 0; n < 3 * SEC && irqOe !== 1'b1; n++) @(posedge clock);
      `CHK(irqOe, 1'b1)
      rd(`OFF_REG_C, 8'hB0);
      `CHK(irqOe, 1'b0)
      foreach (tn[i]) rd(6'(i), tn[i]);
      $display("test update done");
      powerSenseIn <= 1'b0;
      repeat (6) @(posedge clock);
      rd(`OFF_REG_D, 8'h00, 8'h80);
      powerSenseIn <= 1'b1;
      repeat (6) @(posedge clock);
      rd(`OFF_REG_D, 8'h00, 8'h00);
      rd(`OFF_REG_D, 8'h80, 8'h80);
      $display("test power sense done");
      // Reset while an interrupt is pending
      for (int n = 0; n < 2 * SEC && irqOe !== 1'b1; n++) @(posedge clock);
      nrst <= 1'b0;
      repeat (3) @(posedge clock);
      `CHK(irqOe, 1'b0)
      nrst <= 1'b1;
      repeat (4) @(posedge clock);
      rd(ramA, ramD);
      rd(`OFF_REG_B, 8'h00, 8'h78);
      $display("test reset done");
      stop_test();
   end
endmodule
